// ===== logic/fls_supervisor.sv
`timescale 1ns/1ps

// Overview of operation
// - fault input leaving the window latches the controller off, gate drive stops
// - high excursions under 50 us, low under 350 us, are blanked
// - latch released only by brown-out or supply reset level
// - both detectors ignored until start; at start check high fault first
// - low (over-temperature) fault ignored until soft-start has completed
// - thermistor bias current doubled during soft-start, normal afterwards
// - thermal shutdown stops switching, turns off start-up source, resets the sequencer but keeps the latch
// - thermal clear re-enables start-up source and restarts from the beginning unless latched
// - soft-start raises setpoint in 15 steps; completion arms low detection
module fls_supervisor #(
  parameter int unsigned HI_BLANK = fls_pkg::HI_BLANK_CYC,
  parameter int unsigned LO_BLANK = fls_pkg::LO_BLANK_CYC,
  parameter int unsigned SS_STEP  = fls_pkg::SS_STEP_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // analog front end (asynchronous levels)
  input  wire logic        fault_hi_cmp,
  input  wire logic        fault_lo_cmp,
  input  wire logic        brown_out,
  input  wire logic        vcc_reset_level,
  input  wire logic        vcc_on,
  input  wire logic        thermal_trip,
  input  wire logic        fb_takeover,
  // drive and bias controls
  output logic             gate_drive_out,
  output logic             boosted_bias_current,
  output logic             hv_source_en,
  output logic [3:0]       soft_start_step,
  output logic             latched_off,
  output logic             irq,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  // counters are 16 bits wide and need at least one cycle per stage
  if (HI_BLANK < 1 || LO_BLANK < 1 || SS_STEP < 1) begin : g_bad_min
    $error("fls_supervisor: counts must be at least 1");
  end
  if (HI_BLANK > 65535 || LO_BLANK > 65535 || SS_STEP > 65535) begin : g_bad_max
    $error("fls_supervisor: counts must not exceed 65535");
  end

  // ******************************************************
  // input synchronisers
  // ******************************************************
  logic [fls_pkg::IN_W-1:0] raw_in;
  logic [fls_pkg::IN_W-1:0] s1_reg;
  logic [fls_pkg::IN_W-1:0] s2_reg;
  logic [fls_pkg::IN_W-1:0] s3_reg;
  logic [fls_pkg::IN_W-1:0] flt_reg;

  assign raw_in = {fb_takeover, thermal_trip, vcc_on, vcc_reset_level, brown_out, fault_lo_cmp, fault_hi_cmp};

  genvar gi;
  generate
    for (gi = 0; gi < fls_pkg::IN_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_reg[gi]  <= 1'b0;
          s2_reg[gi]  <= 1'b0;
          s3_reg[gi]  <= 1'b0;
          flt_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= raw_in[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            flt_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  logic hi_f;
  logic lo_f;
  logic reset_ev;
  logic von_f;
  logic therm_f;
  logic fb_f;

  assign hi_f     = flt_reg[fls_pkg::IN_HI];
  assign lo_f     = flt_reg[fls_pkg::IN_LO];
  assign reset_ev = flt_reg[fls_pkg::IN_BO] | flt_reg[fls_pkg::IN_VRST];
  assign von_f    = flt_reg[fls_pkg::IN_VON];
  assign therm_f  = flt_reg[fls_pkg::IN_THERM];
  assign fb_f     = flt_reg[fls_pkg::IN_FB];

  // ******************************************************
  // fault qualification
  // ******************************************************
  fls_pkg::fls_state_t state_reg;
  logic [15:0]         hi_cnt_reg;
  logic [15:0]         lo_cnt_reg;
  logic                hi_arm;
  logic                lo_arm;
  logic                hi_trip;
  logic                lo_trip;

  assign hi_arm  = von_f && !therm_f && (state_reg != fls_pkg::FLS_LATCHED) && (state_reg != fls_pkg::FLS_THERMAL);
  assign lo_arm  = hi_arm && (state_reg == fls_pkg::FLS_RUN);
  assign hi_trip = hi_arm && hi_f && (hi_cnt_reg >= 16'(HI_BLANK));
  assign lo_trip = lo_arm && lo_f && (lo_cnt_reg >= 16'(LO_BLANK));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt_reg <= 16'h0000;
    end else if (!(hi_arm && hi_f)) begin
      hi_cnt_reg <= 16'h0000;
    end else if (hi_cnt_reg < 16'(HI_BLANK)) begin
      hi_cnt_reg <= hi_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_cnt_reg <= 16'h0000;
    end else if (!(lo_arm && lo_f)) begin
      lo_cnt_reg <= 16'h0000;
    end else if (lo_cnt_reg < 16'(LO_BLANK)) begin
      lo_cnt_reg <= lo_cnt_reg + 16'h0001;
    end
  end

  // ******************************************************
  // soft-start timing
  // ******************************************************
  logic [15:0] ss_cnt_reg;
  logic [3:0]  ss_step_reg;
  logic        ss_done;

  assign ss_done = (state_reg == fls_pkg::FLS_SOFT) && !therm_f && von_f && !reset_ev && !hi_trip
                   && (fb_f || (ss_step_reg == 4'(fls_pkg::SS_STEPS) && ss_cnt_reg >= 16'(SS_STEP - 1)));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ss_cnt_reg  <= 16'h0000;
      ss_step_reg <= 4'h0;
    end else if (state_reg != fls_pkg::FLS_SOFT) begin
      ss_cnt_reg  <= 16'h0000;
      ss_step_reg <= (state_reg == fls_pkg::FLS_RUN) ? 4'(fls_pkg::SS_STEPS) : 4'h1;
    end else if (ss_cnt_reg >= 16'(SS_STEP - 1)) begin
      ss_cnt_reg <= 16'h0000;
      if (ss_step_reg < 4'(fls_pkg::SS_STEPS)) begin
        ss_step_reg <= ss_step_reg + 4'h1;
      end
    end else begin
      ss_cnt_reg <= ss_cnt_reg + 16'h0001;
    end
  end

  // ******************************************************
  // sequencer
  // ******************************************************
  logic latch_reg;
  logic ctrl_en_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_reg <= 1'b0;
    end else if (reset_ev) begin
      latch_reg <= 1'b0;
    end else if (hi_trip || lo_trip) begin
      latch_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= fls_pkg::FLS_WAIT_VCC;
    end else if (therm_f) begin
      state_reg <= fls_pkg::FLS_THERMAL;
    end else if (reset_ev) begin
      state_reg <= fls_pkg::FLS_WAIT_VCC;
    end else if (latch_reg || hi_trip || lo_trip) begin
      state_reg <= fls_pkg::FLS_LATCHED;
    end else begin
      case (state_reg)
        fls_pkg::FLS_WAIT_VCC: begin
          if (von_f && !hi_f) begin
            state_reg <= fls_pkg::FLS_SOFT;
          end
        end
        fls_pkg::FLS_SOFT: begin
          if (!von_f) begin
            state_reg <= fls_pkg::FLS_WAIT_VCC;
          end else if (ss_done) begin
            state_reg <= fls_pkg::FLS_RUN;
          end
        end
        fls_pkg::FLS_RUN: begin
          if (!von_f) begin
            state_reg <= fls_pkg::FLS_WAIT_VCC;
          end
        end
        fls_pkg::FLS_LATCHED: begin
          state_reg <= fls_pkg::FLS_LATCHED;
        end
        fls_pkg::FLS_THERMAL: begin
          state_reg <= fls_pkg::FLS_WAIT_VCC;
        end
        default: begin
          state_reg <= fls_pkg::FLS_WAIT_VCC;
        end
      endcase
    end
  end

  // ******************************************************
  // outputs to the power stage
  // ******************************************************
  logic switching;

  assign switching = ((state_reg == fls_pkg::FLS_SOFT) || (state_reg == fls_pkg::FLS_RUN)) && !latch_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_drive_out       <= 1'b0;
      boosted_bias_current <= 1'b0;
      hv_source_en         <= 1'b1;
      soft_start_step      <= 4'h0;
      latched_off          <= 1'b0;
    end else begin
      gate_drive_out       <= switching && ctrl_en_reg && !therm_f && !hi_trip && !lo_trip;
      boosted_bias_current <= (state_reg == fls_pkg::FLS_SOFT) && !therm_f;
      hv_source_en         <= !therm_f;
      soft_start_step      <= (switching && !therm_f) ? ss_step_reg : 4'h0;
      latched_off          <= latch_reg;
    end
  end

  // ******************************************************
  // ahb-lite registers and interrupt
  // ******************************************************
  logic                    wr_pend_reg;
  logic [7:0]              wr_addr_reg;
  logic [fls_pkg::EV_W-1:0] irq_stat_reg;
  logic [fls_pkg::EV_W-1:0] irq_mask_reg;
  logic [fls_pkg::EV_W-1:0] ev_set;
  logic [fls_pkg::EV_W-1:0] ev_clr;
  logic                    addr_ok;

  assign addr_ok = hsel && hready && (htrans == fls_pkg::HTRANS_NONSEQ);
  assign ev_set  = {ss_done, therm_f && (state_reg != fls_pkg::FLS_THERMAL), lo_trip, hi_trip};
  assign ev_clr  = (wr_pend_reg && wr_addr_reg == fls_pkg::IRQ_STAT_OFS) ? hwdata[fls_pkg::EV_W-1:0]
                                                                         : {fls_pkg::EV_W{1'b0}};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_en_reg  <= fls_pkg::CTRL_RST;
      irq_mask_reg <= fls_pkg::IRQ_MASK_RST;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == fls_pkg::CTRL_OFS) begin
        ctrl_en_reg <= hwdata[0];
      end
      if (wr_addr_reg == fls_pkg::IRQ_MASK_OFS) begin
        irq_mask_reg <= hwdata[fls_pkg::EV_W-1:0];
      end
    end
  end

  // set wins over a simultaneous write-one-to-clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_reg <= {fls_pkg::EV_W{1'b0}};
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_reg & ~ev_clr) | ev_set) & irq_mask_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite) begin
        case (haddr)
          fls_pkg::CTRL_OFS:     hrdata <= {31'h0000_0000, ctrl_en_reg};
          fls_pkg::STATE_OFS:    hrdata <= {23'h00_0000, latch_reg, ss_step_reg, 1'b0, state_reg};
          fls_pkg::IRQ_STAT_OFS: hrdata <= {28'h000_0000, irq_stat_reg};
          fls_pkg::IRQ_MASK_OFS: hrdata <= {28'h000_0000, irq_mask_reg};
          default:               hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ===== logic/fls_pkg.sv
package fls_pkg;

  // ******************************************************
  // timing
  // ******************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned HI_BLANK_NS   = 50000;
  localparam int unsigned LO_BLANK_NS   = 350000;
  localparam int unsigned SS_TOTAL_NS   = 4000000;
  localparam int unsigned SS_STEPS      = 15;
  localparam int unsigned HI_BLANK_CYC  = (HI_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LO_BLANK_CYC  = (LO_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SS_STEP_CYC   = SS_TOTAL_NS / (SS_STEPS * CLK_PERIOD_NS);

  // ******************************************************
  // register map (byte addresses)
  // ******************************************************
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATE_OFS    = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

  localparam logic [0:0] CTRL_RST     = 1'h1;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // irq bit positions
  localparam int unsigned EV_HI_LATCH = 0;
  localparam int unsigned EV_LO_LATCH = 1;
  localparam int unsigned EV_THERMAL  = 2;
  localparam int unsigned EV_SS_DONE  = 3;
  localparam int unsigned EV_W        = 4;

  // synchronised input positions
  localparam int unsigned IN_HI    = 0;
  localparam int unsigned IN_LO    = 1;
  localparam int unsigned IN_BO    = 2;
  localparam int unsigned IN_VRST  = 3;
  localparam int unsigned IN_VON   = 4;
  localparam int unsigned IN_THERM = 5;
  localparam int unsigned IN_FB    = 6;
  localparam int unsigned IN_W     = 7;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    FLS_WAIT_VCC = 3'b000,
    FLS_SOFT     = 3'b001,
    FLS_RUN      = 3'b010,
    FLS_LATCHED  = 3'b011,
    FLS_THERMAL  = 3'b100
  } fls_state_t;

endpackage

// ===== testbench/fls_afe_model.sv
`timescale 1ns/1ps

// ******************************************************
// analog front end: pin, supply and die levels to comparator flags
// ******************************************************
module fls_afe_model #(
  parameter logic [7:0] HI_TH  = 8'h50,
  parameter logic [7:0] LO_TH  = 8'h14,
  parameter logic [7:0] ON_TH  = 8'h0c,
  parameter logic [7:0] RST_TH = 8'h06
) (
  // stimulus levels
  input  wire logic [7:0] latch_pin_v,
  input  wire logic [7:0] vcc_v,
  input  wire logic       die_hot,
  // comparator flags
  output logic            fault_hi_cmp,
  output logic            fault_lo_cmp,
  output logic            vcc_on,
  output logic            vcc_reset_level,
  output logic            thermal_trip
);
  assign fault_hi_cmp    = latch_pin_v > HI_TH;
  assign fault_lo_cmp    = latch_pin_v < LO_TH;
  assign vcc_on          = vcc_v >= ON_TH;
  assign vcc_reset_level = vcc_v < RST_TH;
  assign thermal_trip    = die_hot;
endmodule

// ===== testbench/fls_supervisor_properties.sv
`timescale 1ns/1ps

// ******************************************************
// port checker
// ******************************************************
module fls_supervisor_props #(
  parameter int unsigned HI_BLANK = 8,
  parameter int unsigned LO_BLANK = 20,
  parameter int unsigned SS_STEP  = 10
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // watched design ports
  input wire logic       fault_hi_cmp,
  input wire logic       brown_out,
  input wire logic       vcc_reset_level,
  input wire logic       vcc_on,
  input wire logic       thermal_trip,
  input wire logic       gate_drive_out,
  input wire logic       boosted_bias_current,
  input wire logic       hv_source_en,
  input wire logic [3:0] soft_start_step,
  input wire logic       latched_off,
  input wire logic       hreadyout,
  input wire logic       hresp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // run length of an armed high fault; restarts only once the start-up source is back on
  logic [16:0] hi_run;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_run <= 17'h0;
    end else if (!(fault_hi_cmp && vcc_on && !thermal_trip && hv_source_en && !brown_out && !vcc_reset_level)) begin
      hi_run <= 17'h0;
    end else if (hi_run != 17'h1ffff) begin
      hi_run <= hi_run + 17'h1;
    end
  end
  sequence s_no_release;
    latched_off && !brown_out && !vcc_reset_level;
  endsequence
  property p_hi_trip;    hi_run == HI_BLANK + 6 |-> latched_off; endproperty
  property p_latch_hold; s_no_release [*6] |=> latched_off; endproperty
  property p_latch_gate; latched_off |-> !gate_drive_out; endproperty
  property p_therm_off;  thermal_trip [*6] |=> !hv_source_en && !gate_drive_out; endproperty
  property p_therm_on;   (!thermal_trip) [*6] |=> hv_source_en; endproperty
  property p_hv_quiet;   !hv_source_en |-> !gate_drive_out && soft_start_step == 4'h0; endproperty
  property p_step_inc;
    boosted_bias_current && $changed(soft_start_step) && soft_start_step != 4'h0
      |-> soft_start_step == $past(soft_start_step) + 4'h1;
  endproperty
  property p_gate_step;  gate_drive_out |-> soft_start_step != 4'h0; endproperty
  property p_boost_ok;   boosted_bias_current |-> !latched_off && hv_source_en; endproperty
  property p_bus_ok;     hreadyout && !hresp; endproperty
  a_hi_trip:    assert property (p_hi_trip) else $error("high fault did not latch");
  a_latch_hold: assert property (p_latch_hold) else $error("latch released early");
  a_latch_gate: assert property (p_latch_gate) else $error("gate on while latched");
  a_therm_off:  assert property (p_therm_off) else $error("thermal did not stop");
  a_therm_on:   assert property (p_therm_on) else $error("start-up source off");
  a_hv_quiet:   assert property (p_hv_quiet) else $error("activity in thermal");
  a_step_inc:   assert property (p_step_inc) else $error("soft-start step skipped");
  a_gate_step:  assert property (p_gate_step) else $error("gate outside start");
  a_boost_ok:   assert property (p_boost_ok) else $error("bias boost out of place");
  a_bus_ok:     assert property (p_bus_ok) else $error("bus response wrong");
endmodule

bind fls_supervisor fls_supervisor_props #(
  .HI_BLANK(HI_BLANK),
  .LO_BLANK(LO_BLANK),
  .SS_STEP (SS_STEP)
) u_props (
  .clk                  (clk),
  .rst_b                (rst_b),
  .fault_hi_cmp         (fault_hi_cmp),
  .brown_out            (brown_out),
  .vcc_reset_level      (vcc_reset_level),
  .vcc_on               (vcc_on),
  .thermal_trip         (thermal_trip),
  .gate_drive_out       (gate_drive_out),
  .boosted_bias_current (boosted_bias_current),
  .hv_source_en         (hv_source_en),
  .soft_start_step      (soft_start_step),
  .latched_off          (latched_off),
  .hreadyout            (hreadyout),
  .hresp                (hresp)
);

// ===== testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  typedef struct packed {logic [7:0] v; logic [7:0] len; logic exp;} fls_row_t;
  logic        clk, rst_b, brown_out, fb_takeover, die_hot, hready, hsel, hwrite;
  logic        fault_hi_cmp, fault_lo_cmp, vcc_on, vcc_reset_level, thermal_trip;
  logic        gate_drive_out, boosted_bias_current, hv_source_en, latched_off, irq, hreadyout, hresp;
  logic [3:0]  soft_start_step;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  latch_pin_v, vcc_v, haddr;
  logic [31:0] hwdata, hrdata, rd;
  int          bad_count, cmp_count, cyc;
  fls_row_t    rows [4] = '{'{8'h5a, 8'h05, 1'b0}, '{8'h5a, 8'h10, 1'b1},
                            '{8'h0a, 8'h10, 1'b0}, '{8'h0a, 8'h20, 1'b1}};
  assign hready = hreadyout;
  fls_afe_model u_afe (
    .latch_pin_v     (latch_pin_v),
    .vcc_v           (vcc_v),
    .die_hot         (die_hot),
    .fault_hi_cmp    (fault_hi_cmp),
    .fault_lo_cmp    (fault_lo_cmp),
    .vcc_on          (vcc_on),
    .vcc_reset_level (vcc_reset_level),
    .thermal_trip    (thermal_trip)
  );
  fls_supervisor #(.HI_BLANK(8), .LO_BLANK(20), .SS_STEP(10)) uut (
    .clk                  (clk),
    .rst_b                (rst_b),
    .fault_hi_cmp         (fault_hi_cmp),
    .fault_lo_cmp         (fault_lo_cmp),
    .brown_out            (brown_out),
    .vcc_reset_level      (vcc_reset_level),
    .vcc_on               (vcc_on),
    .thermal_trip         (thermal_trip),
    .fb_takeover          (fb_takeover),
    .gate_drive_out       (gate_drive_out),
    .boosted_bias_current (boosted_bias_current),
    .hv_source_en         (hv_source_en),
    .soft_start_step      (soft_start_step),
    .latched_off          (latched_off),
    .irq                  (irq),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hready),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .hrdata               (hrdata)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk1(input logic a, input logic e);
    cmp_count++;
    if (a !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic chk32(input logic [31:0] a, input logic [31:0] e);
    cmp_count++;
    if (a !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= fls_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic power_up();
    vcc_v <= 8'h00;
    tick(10);
    vcc_v <= 8'h0f;
    tick(200);
  endtask
  initial begin
    rst_b = 1'b0;
    brown_out = 1'b0;
    fb_takeover = 1'b0;
    die_hot = 1'b0;
    latch_pin_v = 8'h32;
    vcc_v = 8'h00;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tick(16);
    rst_b <= 1'b1;
    tick(1);
    chk1(hv_source_en, 1'b1);
    chk1(latched_off, 1'b0);
    bus(1'b0, fls_pkg::CTRL_OFS, 32'h0, rd);
    chk32(rd, 32'h1);
    bus(1'b0, fls_pkg::IRQ_MASK_OFS, 32'h0, rd);
    chk32(rd, 32'h0);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk32(rd, 32'h0);
    // fault held before the supply is up
    latch_pin_v <= 8'h5a;
    tick(40);
    chk1(latched_off, 1'b0);
    vcc_v <= 8'h0f;
    tick(30);
    chk1(latched_off, 1'b1);
    chk1(gate_drive_out, 1'b0);
    latch_pin_v <= 8'h32;
    brown_out <= 1'b1;
    tick(10);
    brown_out <= 1'b0;
    tick(10);
    chk1(latched_off, 1'b0);
    // low fault during soft-start
    vcc_v <= 8'h00;
    tick(10);
    vcc_v <= 8'h0f;
    tick(20);
    chk1(boosted_bias_current, 1'b1);
    latch_pin_v <= 8'h0a;
    tick(40);
    latch_pin_v <= 8'h32;
    chk1(latched_off, 1'b0);
    tick(120);
    chk1(boosted_bias_current, 1'b0);
    bus(1'b0, fls_pkg::STATE_OFS, 32'h0, rd);
    chk32(rd & 32'hff, 32'hf2);
    foreach (rows[i]) begin
      power_up();
      chk1(gate_drive_out, 1'b1);
      latch_pin_v <= rows[i].v;
      tick(rows[i].len);
      latch_pin_v <= 8'h32;
      tick(10);
      chk1(latched_off, rows[i].exp);
      chk1(gate_drive_out, !rows[i].exp);
    end
    fb_takeover <= 1'b1;
    tick(40);
    chk1(latched_off, 1'b1);
    fb_takeover <= 1'b0;
    vcc_v <= 8'h04;
    tick(10);
    chk1(latched_off, 1'b0);
    vcc_v <= 8'h0f;
    tick(30);
    chk1(boosted_bias_current, 1'b1);
    fb_takeover <= 1'b1;
    tick(10);
    chk1(boosted_bias_current, 1'b0);
    fb_takeover <= 1'b0;
    // thermal shutdown with its interrupt
    bus(1'b1, fls_pkg::IRQ_MASK_OFS, 32'h4, rd);
    die_hot <= 1'b1;
    tick(8);
    chk1(hv_source_en, 1'b0);
    chk1(gate_drive_out, 1'b0);
    tick(2);
    chk1(irq, 1'b1);
    bus(1'b0, fls_pkg::STATE_OFS, 32'h0, rd);
    chk32(rd & 32'h7, 32'h4);
    bus(1'b1, fls_pkg::IRQ_STAT_OFS, 32'h4, rd);
    tick(2);
    chk1(irq, 1'b0);
    die_hot <= 1'b0;
    tick(10);
    chk1(hv_source_en, 1'b1);
    tick(10);
    chk1(boosted_bias_current, 1'b1);
    tick(200);
    bus(1'b1, fls_pkg::CTRL_OFS, 32'h0, rd);
    tick(2);
    chk1(gate_drive_out, 1'b0);
    bus(1'b1, fls_pkg::CTRL_OFS, 32'h1, rd);
    tick(2);
    chk1(gate_drive_out, 1'b1);
    // mid-run reset with the gate disabled: enable returns, start-up begins afresh
    bus(1'b1, fls_pkg::CTRL_OFS, 32'h0, rd);
    rst_b <= 1'b0;
    tick(2);
    chk1(hv_source_en, 1'b1);
    chk1(gate_drive_out, 1'b0);
    rst_b <= 1'b1;
    tick(1);
    chk1(latched_off, 1'b0);
    bus(1'b0, fls_pkg::CTRL_OFS, 32'h0, rd);
    chk32(rd, 32'h1);
    tick(20);
    chk1(boosted_bias_current, 1'b1);
    chk1(gate_drive_out, 1'b1);
    stop_test();
  end
endmodule
